// ### stp_ctrl_regs.sv
/*
 * Stepper step, resolution, fault and lock registers with their outputs.
 * Assumes asynchronous pins and fault inputs
 * and a host that speaks the 16-bit serial frame.
 */
`timescale 1ns/1ps
`include "stp_consts.svh"

module stp_ctrl_regs
   import stp_pkg::*;
#(
   parameter int RETRY_CYC = 100
)
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic spi_sclk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sdi_in,
   output logic spi_sdo_out,
   output logic spi_sdo_oe_out,
   input wire logic step_pin_in,
   input wire logic dir_pin_in,
   input wire logic overcurrent_in,
   input wire logic overheat_in,
   input wire logic temp_warning_in,
   input wire logic vcc_uvlo_in,
   input wire logic sleep_reset_in,
   output logic step_pulse_out,
   output logic dir_forward_out,
   output logic [3:0] microstep_log2_out,
   output logic full_step_reduced_out,
   output logic half_noncircular_out,
   output logic res_reserved_out,
   output logic bridge_disable_out,
   output logic fault_out_n,
   output logic power_on_indicator_out,
   output logic locked_out
);

   // ****************************************************************
   // Resolution decode
   // ****************************************************************
   function automatic stp_res_t decode_res(input logic [3:0] code);
      stp_res_t r;
      r = '0;
      case (code)
         `STP_RES_FULL_100: r.log2 = 4'h0;
         `STP_RES_FULL_71: begin
            r.log2 = 4'h0;
            r.reduced = 1'b1;
         end
         `STP_RES_HALF_NC: begin
            r.log2 = 4'h1;
            r.noncirc = 1'b1;
         end
         `STP_RES_HALF: r.log2 = 4'h1;
         default: begin
            if (code >= `STP_RES_QUARTER && code <= `STP_RES_LAST) begin
               r.log2 = code - `STP_RES_LOG2_OFS;
            end else begin
               r.reserved = 1'b1;
            end
         end
      endcase
      return r;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic [NSYNC-1:0] sync3_ff;
   assign pins = {sleep_reset_in, vcc_uvlo_in, temp_warning_in, overheat_in,
                  overcurrent_in, dir_pin_in, step_pin_in};

   // Third stage only serves edge detection; stage one feeds stage two alone.
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
               sync3_ff[gi] <= 1'b0;
            end else if (ce_in) begin
               sync1_ff[gi] <= pins[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
            end
         end
      end
   endgenerate

   logic step_rise, dir_s, oc_s, oh_s, warn_s, uvlo_s, sleep_rise;
   assign step_rise = sync2_ff[0] & ~sync3_ff[0];
   assign dir_s = sync2_ff[1];
   assign oc_s = sync2_ff[2];
   assign oh_s = sync2_ff[3];
   assign warn_s = sync2_ff[4];
   assign uvlo_s = sync2_ff[5];
   assign sleep_rise = sync2_ff[6] & ~sync3_ff[6];

   // ****************************************************************
   // Serial access
   // ****************************************************************
   logic [5:0] rd_addr;
   logic [7:0] rd_data;
   logic req_valid;
   stp_spi_req_t req;

   stp_spi_shift u_spi (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .sclk_in(spi_sclk_in),
      .cs_n_in(spi_cs_n_in),
      .sdi_in(spi_sdi_in),
      .rd_data_in(rd_data),
      .rd_addr_out(rd_addr),
      .sdo_out(spi_sdo_out),
      .sdo_oe_out(spi_sdo_oe_out),
      .req_valid_out(req_valid),
      .req_out(req)
   );

   // ****************************************************************
   // Registers
   // ****************************************************************
   stp_step_reg_t step_reg_ff, nxt_step_reg;
   stp_fault_reg_t fault_reg_ff, nxt_fault_reg;
   stp_fault_reg_t wr_fault;
   logic locked, wr_step, wr_fault_sel;
   logic por_ff, nxt_por;

   assign locked = (fault_reg_ff.lock == `STP_LOCK_KEY);
   assign wr_step = req_valid & ~req.rd & (req.addr == `STP_ADDR_STEP_SRC);
   assign wr_fault_sel = req_valid & ~req.rd & (req.addr == `STP_ADDR_FAULT_LOCK);
   assign wr_fault = stp_fault_reg_t'(req.data);

   // Self-clearing bits stand high one cycle after their write.
   always_comb begin
      nxt_step_reg = step_reg_ff;
      nxt_step_reg.step = 1'b0;
      nxt_fault_reg = fault_reg_ff;
      nxt_fault_reg.fault_clear = 1'b0;
      if (wr_step && !locked) begin
         nxt_step_reg = stp_step_reg_t'(req.data);
      end
      if (wr_fault_sel) begin
         nxt_fault_reg.fault_clear = wr_fault.fault_clear;
         if (!locked && wr_fault.lock == `STP_LOCK_KEY) begin
            nxt_fault_reg.lock = `STP_LOCK_KEY;
         end
         if (locked && wr_fault.lock == `STP_UNLOCK_KEY) begin
            nxt_fault_reg.lock = `STP_UNLOCK_KEY;
         end
         if (!locked) begin
            nxt_fault_reg.dgl_sel = wr_fault.dgl_sel;
            nxt_fault_reg.oc_recovery = wr_fault.oc_recovery;
            nxt_fault_reg.oh_recovery = wr_fault.oh_recovery;
            nxt_fault_reg.warn_report = wr_fault.warn_report;
         end
      end
      // An undervoltage that arrives with a clear wins, so it is never missed.
      if (uvlo_s) begin
         nxt_por = 1'b0;
      end else if (fault_reg_ff.fault_clear || sleep_rise) begin
         nxt_por = 1'b1;
      end else begin
         nxt_por = por_ff;
      end
   end

   // Register storage; the indicator starts low since power-up is an undervoltage.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         step_reg_ff <= stp_step_reg_t'(`STP_RST_STEP_SRC);
         fault_reg_ff <= stp_fault_reg_t'(`STP_RST_FAULT_LOCK);
         por_ff <= 1'b0;
      end else if (ce_in) begin
         step_reg_ff <= nxt_step_reg;
         fault_reg_ff <= nxt_fault_reg;
         por_ff <= nxt_por;
      end
   end

   // Read mux; self-clearing bits always read back as zero.
   always_comb begin
      rd_data = 8'h00;
      if (rd_addr == `STP_ADDR_STEP_SRC) begin
         rd_data = {step_reg_ff.dir, 1'b0, step_reg_ff[5:0]};
      end else if (rd_addr == `STP_ADDR_FAULT_LOCK) begin
         rd_data = {1'b0, fault_reg_ff[6:0]};
      end else if (rd_addr == `STP_ADDR_DIAG) begin
         rd_data[`STP_DIAG_POR_BIT] = por_ff;
      end
   end

   // ****************************************************************
   // Fault detection
   // ****************************************************************
   logic [7:0] dgl_cnt_ff, nxt_dgl_cnt, dgl_limit;
   logic oc_qual;
   logic [$clog2(RETRY_CYC+1)-1:0] retry_ff, nxt_retry;
   logic oc_latch_ff, nxt_oc_latch, oh_latch_ff, nxt_oh_latch;

   assign dgl_limit = fault_reg_ff.dgl_sel ? 8'(`STP_DGL_LONG_CYC) : 8'(`STP_DGL_SHORT_CYC);
   assign oc_qual = (dgl_cnt_ff >= dgl_limit);

   // A new fault in the clear cycle keeps its latch set.
   always_comb begin
      nxt_dgl_cnt = oc_s ? (oc_qual ? dgl_cnt_ff : dgl_cnt_ff + 8'h01) : 8'h00;
      nxt_oc_latch = (oc_latch_ff & ~fault_reg_ff.fault_clear)
                     | (oc_qual & ~fault_reg_ff.oc_recovery);
      nxt_oh_latch = (oh_latch_ff & ~fault_reg_ff.fault_clear)
                     | (oh_s & ~fault_reg_ff.oh_recovery);
      if (oc_qual && fault_reg_ff.oc_recovery) begin
         nxt_retry = ($bits(retry_ff))'(RETRY_CYC);
      end else if (retry_ff != '0) begin
         nxt_retry = retry_ff - 1'b1;
      end else begin
         nxt_retry = retry_ff;
      end
   end

   // Fault state registers.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dgl_cnt_ff <= 8'h00;
         retry_ff <= '0;
         oc_latch_ff <= 1'b0;
         oh_latch_ff <= 1'b0;
      end else if (ce_in) begin
         dgl_cnt_ff <= nxt_dgl_cnt;
         retry_ff <= nxt_retry;
         oc_latch_ff <= nxt_oc_latch;
         oh_latch_ff <= nxt_oh_latch;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic step_pulse_ff, nxt_step_pulse, dir_ff, nxt_dir;
   logic bridge_dis_ff, nxt_bridge_dis, fault_n_ff, nxt_fault_n, lock_ff;
   stp_res_t res_ff, nxt_res;

   // Auto-retry overheat holds the bridge off only while the condition lasts.
   always_comb begin
      nxt_step_pulse = step_reg_ff.step_src ? step_reg_ff.step : step_rise;
      nxt_dir = step_reg_ff.dir_src ? step_reg_ff.dir : dir_s;
      nxt_res = decode_res(step_reg_ff.res);
      nxt_bridge_dis = oc_latch_ff | (retry_ff != '0) | oh_latch_ff
                       | (oh_s & fault_reg_ff.oh_recovery);
      nxt_fault_n = ~(nxt_bridge_dis | (fault_reg_ff.warn_report & warn_s));
   end

   // Output registers; the fault output idles high.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         step_pulse_ff <= 1'b0;
         dir_ff <= 1'b0;
         res_ff <= '0;
         bridge_dis_ff <= 1'b0;
         fault_n_ff <= 1'b1;
         lock_ff <= 1'b0;
      end else if (ce_in) begin
         step_pulse_ff <= nxt_step_pulse;
         dir_ff <= nxt_dir;
         res_ff <= nxt_res;
         bridge_dis_ff <= nxt_bridge_dis;
         fault_n_ff <= nxt_fault_n;
         lock_ff <= locked;
      end
   end

   assign step_pulse_out = step_pulse_ff;
   assign dir_forward_out = dir_ff;
   assign microstep_log2_out = res_ff.log2;
   assign full_step_reduced_out = res_ff.reduced;
   assign half_noncircular_out = res_ff.noncirc;
   assign res_reserved_out = res_ff.reserved;
   assign bridge_disable_out = bridge_dis_ff;
   assign fault_out_n = fault_n_ff;
   assign power_on_indicator_out = por_ff;
   assign locked_out = lock_ff;

endmodule // stp_ctrl_regs

// ### stp_consts.svh
/*
 * Offsets, fields, resets, keys and timing counts of the stepper control block.
 * Assumes inclusion by bare name.
 */
//
// Contract
// - Register direction bit 1b forward, 0b reverse.
// - Register step write advances exactly one step.
// - Software step bit clears itself after write.
// - Direction source: 0b pin, 1b register bit.
// - Step source: 0b pin, 1b register bit.
// - Codes 0000b/0001b: full step, 100%/71% current.
// - 0010b non-circular half step; 0011b half step.
// - 0100b..1010b: 1/4..1/256; 1011b+ reserved.
// - Fault clear write clears all latched faults.
// - Fault clear bit returns to 0b itself.
// - 110b locks; only lock and clear writable.
// - Unlocked: other lock values leave state unchanged.
// - Writing 011b to lock field unlocks registers.
// - Locked: values other than 011b keep lock.
// - Deglitch select: 1b 2.2 us, 0b 1.2 us.
// - Overcurrent recovery: 0b latched, 1b auto-retry.
// - Overheat recovery: 0b latched, 1b auto-retry.
// - Warning report bit gates warnings onto fault output.
// - After undervoltage, clear or sleep pulse sets indicator.
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define STP_ADDR_STEP_SRC 6'h05
`define STP_ADDR_FAULT_LOCK 6'h06
`define STP_ADDR_DIAG 6'h03
`define STP_RST_STEP_SRC 8'h06
`define STP_RST_FAULT_LOCK 8'h38
`define STP_LOCK_KEY 3'h6
`define STP_UNLOCK_KEY 3'h3
`define STP_DIAG_POR_BIT 2

// ****************************************************************
// Resolution codes
// ****************************************************************
`define STP_RES_FULL_100 4'h0
`define STP_RES_FULL_71 4'h1
`define STP_RES_HALF_NC 4'h2
`define STP_RES_HALF 4'h3
`define STP_RES_QUARTER 4'h4
`define STP_RES_LAST 4'ha
`define STP_RES_LOG2_OFS 4'h2

// ****************************************************************
// Timing, in nanoseconds and derived clock cycles
// ****************************************************************
`define STP_CLK_PERIOD_NS 40
`define STP_DGL_LONG_NS 2200
`define STP_DGL_SHORT_NS 1200
`define STP_DGL_LONG_CYC ((`STP_DGL_LONG_NS + `STP_CLK_PERIOD_NS - 1) / `STP_CLK_PERIOD_NS)
`define STP_DGL_SHORT_CYC ((`STP_DGL_SHORT_NS + `STP_CLK_PERIOD_NS - 1) / `STP_CLK_PERIOD_NS)

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define STP_SPI_LAST_HDR_BIT 4'h7
`define STP_SPI_LAST_BIT 4'hf

`endif

// ### stp_pkg.sv
/*
 * Types of the stepper control block and its serial engine.
 * Assumes nothing of its surroundings.
 */
package stp_pkg;

   // One complete serial request.
   typedef struct packed {
      logic rd;
      logic [5:0] addr;
      logic [7:0] data;
   } stp_spi_req_t;

   // Step source and resolution register layout.
   typedef struct packed {
      logic dir;
      logic step;
      logic dir_src;
      logic step_src;
      logic [3:0] res;
   } stp_step_reg_t;

   // Fault handling and lock register layout.
   typedef struct packed {
      logic fault_clear;
      logic [2:0] lock;
      logic dgl_sel;
      logic oc_recovery;
      logic oh_recovery;
      logic warn_report;
   } stp_fault_reg_t;

   // Decoded resolution.
   typedef struct packed {
      logic [3:0] log2;
      logic reduced;
      logic noncirc;
      logic reserved;
   } stp_res_t;

   typedef enum logic [1:0] {SPI_IDLE, SPI_HDR, SPI_DATA, SPI_WAIT} stp_spi_state_t;

endpackage

// ### stp_spi_shift.sv
/*
 * Serial slave engine: 16-bit frames in, read data out.
 * Assumes sclk idles low with phases of four or more system clocks.
 */
`timescale 1ns/1ps
`include "stp_consts.svh"

module stp_spi_shift
   import stp_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic sdi_in,
   input wire logic [7:0] rd_data_in,
   output logic [5:0] rd_addr_out,
   output logic sdo_out,
   output logic sdo_oe_out,
   output logic req_valid_out,
   output stp_spi_req_t req_out
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] pins;
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic sclk_d_ff;
   assign pins = {sdi_in, cs_n_in, sclk_in};

   // Two stages per pin.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end else if (ce_in) begin
               sync1_ff[gi] <= pins[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Frame engine
   // ****************************************************************
   stp_spi_state_t state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [14:0] rx_ff, nxt_rx;
   logic [7:0] tx_ff, nxt_tx;
   logic sdo_ff, nxt_sdo, oe_ff, nxt_oe, val_ff, nxt_val;
   stp_spi_req_t req_ff, nxt_req;
   logic rise, fall, cs_act, sdi_s;

   assign rise = sync2_ff[0] & ~sclk_d_ff;
   assign fall = ~sync2_ff[0] & sclk_d_ff;
   assign cs_act = ~sync2_ff[1];
   assign sdi_s = sync2_ff[2];
   assign rd_addr_out = {rx_ff[4:0], sdi_s};

   // Chip select high abandons a frame unwritten.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_sdo = sdo_ff;
      nxt_oe = oe_ff;
      nxt_val = 1'b0;
      nxt_req = req_ff;
      if (!cs_act) begin
         nxt_state = SPI_IDLE;
         nxt_oe = 1'b0;
         nxt_sdo = 1'b0;
      end else begin
         case (state_ff)
            SPI_IDLE: begin
               nxt_state = SPI_HDR;
               nxt_cnt = 4'h0;
               nxt_oe = 1'b1;
            end
            SPI_HDR: begin
               if (rise) begin
                  nxt_rx = {rx_ff[13:0], sdi_s};
                  nxt_cnt = cnt_ff + 4'h1;
                  if (cnt_ff == `STP_SPI_LAST_HDR_BIT) begin
                     nxt_tx = rd_data_in;
                     nxt_state = SPI_DATA;
                  end
               end
            end
            SPI_DATA: begin
               if (fall) begin
                  nxt_sdo = tx_ff[7];
                  nxt_tx = {tx_ff[6:0], 1'b0};
               end
               if (rise) begin
                  nxt_rx = {rx_ff[13:0], sdi_s};
                  nxt_cnt = cnt_ff + 4'h1;
                  if (cnt_ff == `STP_SPI_LAST_BIT) begin
                     nxt_val = 1'b1;
                     nxt_req = '{rd: rx_ff[13], addr: rx_ff[12:7], data: {rx_ff[6:0], sdi_s}};
                     nxt_state = SPI_WAIT;
                  end
               end
            end
            default: begin
               nxt_state = SPI_WAIT;
            end
         endcase
      end
   end

   // Registers of the frame engine.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= SPI_IDLE;
         cnt_ff <= 4'h0;
         rx_ff <= 15'h0000;
         tx_ff <= 8'h00;
         sdo_ff <= 1'b0;
         oe_ff <= 1'b0;
         val_ff <= 1'b0;
         req_ff <= '0;
         sclk_d_ff <= 1'b0;
      end else if (ce_in) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         sdo_ff <= nxt_sdo;
         oe_ff <= nxt_oe;
         val_ff <= nxt_val;
         req_ff <= nxt_req;
         sclk_d_ff <= sync2_ff[0];
      end
   end

   assign sdo_out = sdo_ff;
   assign sdo_oe_out = oe_ff;
   assign req_valid_out = val_ff;
   assign req_out = req_ff;

endmodule // stp_spi_shift

// ### stp_ctrl_regs_monitor.sv
/* Checker on the stepper control block's ports.
   Assumes ce_in stays high. */
`timescale 1ns/1ps
module stp_ctrl_regs_monitor #(
   parameter int RETRY_CYC = 100
)
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic overcurrent_in,
   input wire logic overheat_in,
   input wire logic vcc_uvlo_in,
   input wire logic dir_pin_in,
   input wire logic spi_cs_n_in,
   input wire logic step_pulse_out,
   input wire logic dir_forward_out,
   input wire logic [3:0] microstep_log2_out,
   input wire logic full_step_reduced_out,
   input wire logic half_noncircular_out,
   input wire logic res_reserved_out,
   input wire logic bridge_disable_out,
   input wire logic fault_out_n,
   input wire logic power_on_indicator_out
);
   // ****************
   // Run counter and properties
   // ****************
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [7:0] oc_run_ff;
   logic [7:0] nxt_oc_run;
   // Raw overcurrent run length; it saturates so a long fault never wraps to zero.
   always_comb begin
      nxt_oc_run = overcurrent_in ? (oc_run_ff + {7'h00, oc_run_ff != 8'hff}) : 8'h00;
   end
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         oc_run_ff <= 8'h00;
      end else begin
         oc_run_ff <= nxt_oc_run;
      end
   end
   a_reserved_log2: assert property (res_reserved_out |-> microstep_log2_out == 4'h0)
      else $error("reserved code with nonzero resolution");
   a_log2_range: assert property (microstep_log2_out <= 4'h8)
      else $error("resolution beyond 1/256");
   a_reduced_full: assert property (full_step_reduced_out |-> microstep_log2_out == 4'h0)
      else $error("reduced current outside full step");
   a_noncirc_half: assert property (half_noncircular_out |-> microstep_log2_out == 4'h1)
      else $error("non-circular mode outside half step");
   a_flags_exclusive: assert property ($onehot0({full_step_reduced_out,
      half_noncircular_out, res_reserved_out})) else $error("resolution flags overlap");
   a_step_single: assert property (step_pulse_out |=> !step_pulse_out)
      else $error("step pulse too long");
   a_bridge_fault: assert property ($rose(bridge_disable_out) && overcurrent_in
      |-> ##[0:2] !fault_out_n) else $error("bridge off, fault high");
   a_oc_deglitch: assert property ($rose(bridge_disable_out) && !overheat_in
      && !vcc_uvlo_in |-> oc_run_ff >= 8'h1e) else $error("overcurrent taken too early");
   a_uvlo_clears: assert property (vcc_uvlo_in [*6] |-> !power_on_indicator_out)
      else $error("indicator set in undervoltage");
   a_dir_follow: assert property ($changed(dir_forward_out) && spi_cs_n_in
      |-> dir_forward_out == $past(dir_pin_in, 3)) else $error("direction not from pin");
   c_step: cover property (step_pulse_out);
   c_bridge: cover property ($rose(bridge_disable_out));
   c_reserved: cover property (res_reserved_out);
endmodule // stp_ctrl_regs_monitor

bind stp_ctrl_regs stp_ctrl_regs_monitor #(.RETRY_CYC(RETRY_CYC)) u_mon (.*);

// ### stp_host_model.sv
/* Serial host model for 16-bit register frames.
   Assumes one caller and phases of six clocks or more. */
`timescale 1ns/1ps
module stp_host_model (
   input wire logic sys_clk_in,
   input wire logic sdo_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic sdi_out
);
   // ****************
   // Frame engine
   // ****************
   int ph = 6; // Clocks per serial phase; a larger value makes a slow host.
   // The serial clock stands low outside frames.
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   // Sends whatever code the caller hands over, reserved ones only on request.
   task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
      for (int i = 15; i >= 0; i--) begin
         @(posedge sys_clk_in);
         cs_n_out <= 1'b0;
         sclk_out <= 1'b0;
         sdi_out <= frm[i];
         repeat (ph) @(posedge sys_clk_in);
         if (i < 8) rd[i] = sdo_in;
         sclk_out <= 1'b1;
         repeat (ph - 1) @(posedge sys_clk_in);
      end
      @(posedge sys_clk_in);
      sclk_out <= 1'b0;
      repeat (ph) @(posedge sys_clk_in);
      cs_n_out <= 1'b1;
      sdi_out <= ~sdi_out; // A released line must not keep showing its last bit.
      repeat (6) @(posedge sys_clk_in);
   endtask
endmodule // stp_host_model

// ### test_stepper_step_and_fault_control_regs.sv
/* Self-checking bench for the stepper control block.
   Assumes host model and checker compiled first. */
`timescale 1ns/1ps
module test_stepper_step_and_fault_control_regs;
   // ****************
   // Stimulus, scoreboard and tests
   // ****************
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic step_pin = 1'b0, dir_pin = 1'b0, oc = 1'b0, oh = 1'b0, warn = 1'b0, uvlo = 1'b0;
   logic slp = 1'b0, rd_stb = 1'b0;
   logic sclk, cs_n, sdi, sdo, step_p, dir_f, red, nc, rsv, brg, flt_n, por, lck;
   logic [3:0] l2;
   logic [7:0] rd_val;
   logic [7:0] exp_q[$];
   logic [7:0] cfg[4] = '{8'h30, 8'h30, 8'h38, 8'h38};
   logic [7:0] fx[4] = '{8'h01, 8'h02, 8'h01, 8'h02};
   int len[4] = '{25, 45, 45, 70};
   int failures = 0;
   int cmp_count = 0;
   int steps = 0;
   always #20 sys_clk_in = ~sys_clk_in;
   stp_host_model host (.sys_clk_in(sys_clk_in), .sdo_in(sdo), .sclk_out(sclk),
      .cs_n_out(cs_n), .sdi_out(sdi));
   stp_ctrl_regs #(.RETRY_CYC(10)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .ce_in(1'b1), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi),
      .spi_sdo_out(sdo), .spi_sdo_oe_out(), .step_pin_in(step_pin), .dir_pin_in(dir_pin),
      .overcurrent_in(oc), .overheat_in(oh), .temp_warning_in(warn), .vcc_uvlo_in(uvlo),
      .sleep_reset_in(slp), .step_pulse_out(step_p), .dir_forward_out(dir_f),
      .microstep_log2_out(l2), .full_step_reduced_out(red), .half_noncircular_out(nc),
      .res_reserved_out(rsv), .bridge_disable_out(brg), .fault_out_n(flt_n),
      .power_on_indicator_out(por), .locked_out(lck));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] junk;
      host.xfer({2'b00, a, d}, junk);
   endtask
   // Note queued first; the watcher pairs it with the answer.
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer({2'b01, a, 8'h00}, rd_val);
      rd_stb <= 1'b1;
      wt(1);
      rd_stb <= 1'b0;
   endtask
   // Flags and log2 packed as {0, reduced, noncircular, reserved, log2}.
   function automatic logic [7:0] res_exp(input logic [3:0] c);
      if (c > 4'ha) return 8'h10;
      if (c < 4'h2) return {1'b0, c[0], 6'h00};
      if (c == 4'h2) return 8'h21;
      return {4'h0, c - 4'h2};
   endfunction
   // Watcher: answers against oldest note; step pulse tally.
   always @(posedge sys_clk_in) begin
      if (rd_stb) check(rd_val, exp_q.pop_front());
      if (step_p === 1'b1) steps++;
   end
   task automatic complete_run();
      $display("compares=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Watchdog: tests need about 11000 cycles.
   initial begin
      wt(60000);
      failures++;
      complete_run();
   end
   initial begin
      void'($urandom(62668));
      wt(12);
      rst_n_in <= 1'b1;
      wt(4);
      rd(6'h05, 8'h06);
      rd(6'h06, 8'h38);
      rd(6'h3f, 8'h00);
      $display("test reset done");
      // Every code, reserved ones too.
      for (int c = 0; c < 16; c++) begin
         wr(6'h05, 8'(c));
         check({1'b0, red, nc, rsv, l2}, res_exp(4'(c)));
      end
      wr(6'h05, 8'hf6);
      check(8'(steps), 8'h01);
      check(8'(dir_f), 8'h01);
      rd(6'h05, 8'hb6);
      wr(6'h05, 8'h34);
      check(8'(dir_f), 8'h00);
      step_pin <= 1'b1;
      wt(6);
      step_pin <= 1'b0;
      wt(6);
      check(8'(steps), 8'h01);
      wr(6'h05, 8'h04);
      for (int k = 0; k < 4; k++) begin
         dir_pin <= 1'($urandom);
         step_pin <= 1'b1;
         wt(8);
         step_pin <= 1'b0;
         wt(2);
         check(8'(dir_f), 8'(dir_pin));
         check(8'(steps), 8'(k + 2));
      end
      $display("test step done");
      host.ph = 9;
      wr(6'h06, 8'h68);
      check(8'(lck), 8'h01);
      wr(6'h05, 8'h0a);
      rd(6'h05, 8'h04);
      wr(6'h06, 8'h2f);
      rd(6'h06, 8'h68);
      wr(6'h06, 8'h38);
      check(8'(lck), 8'h00);
      wr(6'h06, 8'h0f);
      rd(6'h06, 8'h3f);
      host.ph = 6;
      $display("test lock done");
      for (int i = 0; i < 4; i++) begin
         wr(6'h06, cfg[i]);
         oc <= 1'b1;
         wt(len[i]);
         oc <= 1'b0;
         wt(10);
         check({6'h0, brg, flt_n}, fx[i]);
         wr(6'h06, cfg[i] | 8'h80);
         check({6'h0, brg, flt_n}, 8'h01);
      end
      rd(6'h06, 8'h38);
      wr(6'h06, 8'h34);
      oc <= 1'b1;
      wt(40);
      check({7'h0, brg}, 8'h01);
      wt(5);
      oc <= 1'b0;
      wt(15);
      check({6'h0, brg, flt_n}, 8'h01);
      for (int m = 0; m < 2; m++) begin
         wr(6'h06, m ? 8'h32 : 8'h30);
         oh <= 1'b1;
         wt(8);
         oh <= 1'b0;
         wt(20);
         check({6'h0, brg, flt_n}, m ? 8'h01 : 8'h02);
         wr(6'h06, 8'hb0);
      end
      warn <= 1'b1;
      wt(8);
      check({7'h0, flt_n}, 8'h01);
      wr(6'h06, 8'h31);
      check({7'h0, flt_n}, 8'h00);
      warn <= 1'b0;
      $display("test fault done");
      uvlo <= 1'b1;
      wt(10);
      uvlo <= 1'b0;
      wt(4);
      check({7'h0, por}, 8'h00);
      wr(6'h06, 8'hb0);
      rd(6'h03, 8'h04);
      uvlo <= 1'b1;
      wt(10);
      uvlo <= 1'b0;
      slp <= 1'b1;
      wt(3);
      slp <= 1'b0;
      wt(6);
      check({7'h0, por}, 8'h01);
      $display("test power done");
      complete_run();
   end
endmodule // test_stepper_step_and_fault_control_regs
